/* verilog/homing_status_defines.vh */
// Constants of the homing status and warning logic: register offsets,
// field positions, reset values and warning display codes.
// Assumes inclusion by bare name from the design files.
`ifndef HOMING_STATUS_DEFINES_VH
`define HOMING_STATUS_DEFINES_VH

// Register byte offsets, one aligned 32-bit word each
`define HS_ADDR_CONFIG 8'h00
`define HS_ADDR_METHOD 8'h04
`define HS_ADDR_GEAR_NUM 8'h08
`define HS_ADDR_GEAR_DEN 8'h0c
`define HS_ADDR_STN_DIR 8'h10
`define HS_ADDR_STATIONS 8'h14
`define HS_ADDR_STATUS 8'h18
`define HS_ADDR_CAUSE 8'h1c
`define HS_ADDR_CODE 8'h20

// Config register fields
`define HS_CFG_ABS 0
`define HS_CFG_SERVO_ON 1

// Status register fields
`define HS_ST_HOME_VALID 0
`define HS_ST_WARN 1
`define HS_ST_ABNORMAL 2
`define HS_ST_SERVO_OFF 3
`define HS_ST_REHOME 4
`define HS_ST_HOMING 5
`define HS_ST_FWD_LIMIT 6
`define HS_ST_REV_LIMIT 7
`define HS_ST_W 8

// Cause register fields
`define HS_CA_POS 0
`define HS_CA_CREEP 1
`define HS_CA_STROKE 2
`define HS_CA_JOG 3
`define HS_CA_PARAM 4
`define HS_CA_ERASE 5
`define HS_CA_W 6

// Warning display codes
`define HS_CODE_NONE 16'h0000
`define HS_CODE_HOME_INCOMPLETE 16'h0a90
`define HS_CODE_SERVO_OFF 16'h0ae6

// Reset values
`define HS_RST_WORD 32'h0000_0000
`define HS_RST_ADDR 8'h00

`endif

/* verilog/sync2.v */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the destination clock hclk and its clock enable.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
   parameter W = 2,
   parameter [W-1:0] RST = {W{1'b1}}
) (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   reg [W-1:0] meta;

   // Only the second stage reads the first
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= RST;
         q <= RST;
      end else if (clk_en) begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // sync2

`default_nettype wire

/* verilog/homing_status_warning_logic.v */
// Home position validity tracking and home-incomplete warning for a
// servo drive, with an AHB-Lite register slave.
// Assumes single-clock motion logic on hclk giving one-cycle event pulses,
// and stroke end pins that are high (on) in normal travel.
//
// How it works
// - Servo-off warning active forces the servo-off state.
// - Other warnings leave the running operation enabled.
// - Incremental: positioning before completed home return raises warning.
// - Homing abnormal end on creep failure or stroke trip short of dog.
// - Incremental: jog without prior home return raises warning.
// - Changing method, gear, station direction or count invalidates home.
// - Incremental: successful home return clears the warning by itself.
// - Absolute: positioning before home setting raises warning.
// - Absolute: home setting abnormal on creep failure or stroke trip.
// - Absolute: operation while absolute erase alarm is active raises warning.
// - Absolute: successful home setting clears the warning by itself.
`timescale 1ns/1ps
`default_nettype none
`include "homing_status_defines.vh"

module homing_status_warning_logic #(
   parameter METHOD_W = 4,
   parameter GEAR_W = 16,
   parameter STN_W = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire fwd_stroke_end_limit,
   input wire rev_stroke_end_limit,
   input wire home_start,
   input wire home_beyond_dog,
   input wire home_done,
   input wire home_creep_fail,
   input wire pos_start,
   input wire jog_start,
   input wire abs_erase_alarm,
   input wire abs_counter_warning,
   input wire servo_off_warning,
   output reg home_valid,
   output reg home_incomplete_warn,
   output reg home_abnormal,
   output reg servo_off_force,
   output reg run_enable,
   output reg rehome_advised,
   output reg [15:0] warn_code
);

   // Bus state
   reg wr_pend;
   reg [7:0] wr_addr;

   // Software registers
   reg abs_system;
   reg servo_on_cmd;
   reg [METHOD_W-1:0] operation_method_select;
   reg [GEAR_W-1:0] gear_numerator;
   reg [GEAR_W-1:0] gear_denominator;
   reg station_direction_select;
   reg [STN_W-1:0] stations_per_rotation;

   // Homing state
   reg homing;
   reg start_beyond_dog;
   reg [`HS_CA_W-1:0] cause;

   wire [1:0] limit_sync;
   wire fwd_ok;
   wire rev_ok;

   sync2 #(
      .W(2),
      .RST(2'h3)
   ) u_limit_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .d({rev_stroke_end_limit, fwd_stroke_end_limit}),
      .q(limit_sync)
   );

   assign fwd_ok = limit_sync[0];
   assign rev_ok = limit_sync[1];

   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   function [31:0] zext;
      input [31:0] v;
      input integer w;
      integer i;
      begin
         zext = `HS_RST_WORD;
         for (i = 0; i < 32; i = i + 1) begin
            if (i < w) begin
               zext[i] = v[i];
            end
         end
      end
   endfunction

   // Address phase of a single transfer; hsize is ignored and only haddr[7:0] is decoded
   wire addr_take = hsel && hready && htrans[1];
   wire rd_take = addr_take && !hwrite;

   wire wr_cfg = wr_pend && hit(wr_addr, `HS_ADDR_CONFIG);
   wire wr_method = wr_pend && hit(wr_addr, `HS_ADDR_METHOD);
   wire wr_gnum = wr_pend && hit(wr_addr, `HS_ADDR_GEAR_NUM);
   wire wr_gden = wr_pend && hit(wr_addr, `HS_ADDR_GEAR_DEN);
   wire wr_sdir = wr_pend && hit(wr_addr, `HS_ADDR_STN_DIR);
   wire wr_stn = wr_pend && hit(wr_addr, `HS_ADDR_STATIONS);

   // A rewrite with the same value keeps the home position
   wire param_change =
      (wr_method && (hwdata[METHOD_W-1:0] != operation_method_select)) ||
      (wr_gnum && (hwdata[GEAR_W-1:0] != gear_numerator)) ||
      (wr_gden && (hwdata[GEAR_W-1:0] != gear_denominator)) ||
      (wr_sdir && (hwdata[0] != station_direction_select)) ||
      (wr_stn && (hwdata[STN_W-1:0] != stations_per_rotation));

   // Switching system type also drops the home position
   wire sys_change = wr_cfg && (hwdata[`HS_CFG_ABS] != abs_system);

   // Homing outcome
   wire stroke_trip = homing && !start_beyond_dog &&
      (!fwd_ok || !rev_ok);
   wire creep_trip = homing && home_creep_fail;
   wire abnormal_evt = creep_trip || stroke_trip;
   wire success_evt = homing && home_done && !abnormal_evt;
   wire erase_hold = abs_system && abs_erase_alarm;
   wire op_req = pos_start || jog_start;

   // Warning causes
   wire [`HS_CA_W-1:0] cause_set;
   assign cause_set[`HS_CA_POS] = pos_start && !home_valid;
   assign cause_set[`HS_CA_CREEP] = creep_trip;
   assign cause_set[`HS_CA_STROKE] = stroke_trip;
   assign cause_set[`HS_CA_JOG] = jog_start && !home_valid;
   assign cause_set[`HS_CA_PARAM] = param_change || sys_change;
   assign cause_set[`HS_CA_ERASE] = erase_hold && op_req;

   wire warn_set = |cause_set;

   reg next_home_valid;
   reg next_warn;
   reg [`HS_CA_W-1:0] next_cause;

   always @* begin
      next_home_valid = home_valid;
      if (param_change || sys_change || abnormal_evt || erase_hold) begin
         next_home_valid = 1'b0;
      end else if (success_evt) begin
         next_home_valid = 1'b1;
      end
   end

   // Set wins over the automatic clear
   always @* begin
      next_warn = home_incomplete_warn;
      next_cause = cause;
      if (success_evt) begin
         next_warn = 1'b0;
         next_cause = {`HS_CA_W{1'b0}};
      end
      if (warn_set) begin
         next_warn = 1'b1;
         next_cause = next_cause | cause_set;
      end
   end

   // Bus slave: zero wait states, registered read data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= `HS_RST_ADDR;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= `HS_RST_WORD;
      end else if (clk_en) begin
         wr_pend <= addr_take && hwrite;
         wr_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_take) begin
            hrdata <= read_mux(haddr[7:0]);
         end else begin
            hrdata <= `HS_RST_WORD;
         end
      end
   end

   function [31:0] read_mux;
      input [7:0] a;
      begin
         read_mux = `HS_RST_WORD;
         if (hit(a, `HS_ADDR_CONFIG)) begin
            read_mux[`HS_CFG_ABS] = abs_system;
            read_mux[`HS_CFG_SERVO_ON] = servo_on_cmd;
         end else if (hit(a, `HS_ADDR_METHOD)) begin
            read_mux = zext({{(32-METHOD_W){1'b0}},
               operation_method_select}, METHOD_W);
         end else if (hit(a, `HS_ADDR_GEAR_NUM)) begin
            read_mux = zext({{(32-GEAR_W){1'b0}}, gear_numerator}, GEAR_W);
         end else if (hit(a, `HS_ADDR_GEAR_DEN)) begin
            read_mux = zext({{(32-GEAR_W){1'b0}}, gear_denominator}, GEAR_W);
         end else if (hit(a, `HS_ADDR_STN_DIR)) begin
            read_mux[0] = station_direction_select;
         end else if (hit(a, `HS_ADDR_STATIONS)) begin
            read_mux = zext({{(32-STN_W){1'b0}}, stations_per_rotation},
               STN_W);
         end else if (hit(a, `HS_ADDR_STATUS)) begin
            read_mux[`HS_ST_HOME_VALID] = home_valid;
            read_mux[`HS_ST_WARN] = home_incomplete_warn;
            read_mux[`HS_ST_ABNORMAL] = home_abnormal;
            read_mux[`HS_ST_SERVO_OFF] = servo_off_force;
            read_mux[`HS_ST_REHOME] = rehome_advised;
            read_mux[`HS_ST_HOMING] = homing;
            read_mux[`HS_ST_FWD_LIMIT] = fwd_ok;
            read_mux[`HS_ST_REV_LIMIT] = rev_ok;
         end else if (hit(a, `HS_ADDR_CAUSE)) begin
            read_mux[`HS_CA_W-1:0] = cause;
         end else if (hit(a, `HS_ADDR_CODE)) begin
            read_mux[15:0] = warn_code;
         end
      end
   endfunction

   // Software registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         abs_system <= 1'b0;
         servo_on_cmd <= 1'b0;
         operation_method_select <= {METHOD_W{1'b0}};
         gear_numerator <= {{(GEAR_W-1){1'b0}}, 1'b1};
         gear_denominator <= {{(GEAR_W-1){1'b0}}, 1'b1};
         station_direction_select <= 1'b0;
         stations_per_rotation <= {STN_W{1'b0}};
      end else if (clk_en) begin
         if (wr_cfg) begin
            abs_system <= hwdata[`HS_CFG_ABS];
            servo_on_cmd <= hwdata[`HS_CFG_SERVO_ON];
         end
         if (wr_method) begin
            operation_method_select <= hwdata[METHOD_W-1:0];
         end
         if (wr_gnum) begin
            gear_numerator <= hwdata[GEAR_W-1:0];
         end
         if (wr_gden) begin
            gear_denominator <= hwdata[GEAR_W-1:0];
         end
         if (wr_sdir) begin
            station_direction_select <= hwdata[0];
         end
         if (wr_stn) begin
            stations_per_rotation <= hwdata[STN_W-1:0];
         end
      end
   end

   // Homing run tracking; start position is caught at the start pulse
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         homing <= 1'b0;
         start_beyond_dog <= 1'b0;
         home_abnormal <= 1'b0;
      end else if (clk_en) begin
         if (home_start && !homing) begin
            homing <= 1'b1;
            start_beyond_dog <= home_beyond_dog;
            home_abnormal <= 1'b0;
         end else if (abnormal_evt) begin
            homing <= 1'b0;
            home_abnormal <= 1'b1;
         end else if (home_done) begin
            homing <= 1'b0;
         end
      end
   end

   // Home validity and warning; invalid after power-on
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         home_valid <= 1'b0;
         home_incomplete_warn <= 1'b0;
         cause <= {`HS_CA_W{1'b0}};
      end else if (clk_en) begin
         home_valid <= next_home_valid;
         home_incomplete_warn <= next_warn;
         cause <= next_cause;
      end
   end

   // Servo state and display
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         servo_off_force <= 1'b0;
         run_enable <= 1'b0;
         rehome_advised <= 1'b0;
         warn_code <= `HS_CODE_NONE;
      end else if (clk_en) begin
         servo_off_force <= servo_off_warning;
         // Home warning deliberately absent from this term
         run_enable <= servo_on_cmd && !servo_off_warning;
         // Advice only; host decides when to home again
         if (abs_counter_warning || !fwd_ok || !rev_ok) begin
            rehome_advised <= 1'b1;
         end else if (success_evt) begin
            rehome_advised <= 1'b0;
         end
         if (servo_off_warning) begin
            warn_code <= `HS_CODE_SERVO_OFF;
         end else if (next_warn) begin
            warn_code <= `HS_CODE_HOME_INCOMPLETE;
         end else begin
            warn_code <= `HS_CODE_NONE;
         end
      end
   end

endmodule // homing_status_warning_logic

`default_nettype wire

/* test/homing_props.sv */
// Checker for the homing status block, watching top-level ports.
// Assumes one clock hclk and the active-low reset hresetn.
`timescale 1ns/1ps
`default_nettype none
`include "homing_status_defines.vh"
module homing_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic pos_start,
   input wire logic jog_start,
   input wire logic servo_off_warning,
   input wire logic home_valid,
   input wire logic home_incomplete_warn,
   input wire logic home_abnormal,
   input wire logic servo_off_force,
   input wire logic run_enable,
   input wire logic [15:0] warn_code
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_so_force;
      servo_off_warning && clk_en |=> servo_off_force && !run_enable;
   endproperty
   a_so_force: assert property (p_so_force)
      else $error("servo off not forced");
   property p_so_code;
      servo_off_force |-> warn_code == `HS_CODE_SERVO_OFF;
   endproperty
   a_so_code: assert property (p_so_code)
      else $error("servo off code wrong");
   property p_run_keep;
      $rose(home_incomplete_warn) && run_enable && !servo_off_warning
         |=> run_enable;
   endproperty
   a_run_keep: assert property (p_run_keep)
      else $error("run stopped by warning");
   property p_pos;
      pos_start && clk_en && !home_valid |=> home_incomplete_warn;
   endproperty
   a_pos: assert property (p_pos)
      else $error("no warning on positioning");
   property p_code;
      home_incomplete_warn && !servo_off_force
         |-> warn_code == `HS_CODE_HOME_INCOMPLETE;
   endproperty
   a_code: assert property (p_code)
      else $error("home warning code wrong");
   property p_jog;
      jog_start && clk_en && !home_valid |=> home_incomplete_warn;
   endproperty
   a_jog: assert property (p_jog)
      else $error("no warning on jog");
   property p_abn;
      $rose(home_abnormal) |-> !home_valid && home_incomplete_warn;
   endproperty
   a_abn: assert property (p_abn)
      else $error("abnormal end kept home");
   property p_clear;
      $rose(home_valid) && !$past(pos_start) && !$past(jog_start)
         |-> !home_incomplete_warn;
   endproperty
   a_clear: assert property (p_clear)
      else $error("warning not cleared");
   property p_por;
      $rose(hresetn) |-> !home_valid [*2];
   endproperty
   a_por: assert property (p_por)
      else $error("home valid after reset");
   c_valid: cover property ($rose(home_valid));
   c_warn: cover property ($rose(home_incomplete_warn));
   c_abn: cover property ($rose(home_abnormal));
endmodule // homing_props
bind homing_status_warning_logic homing_props u_props (
   .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .pos_start(pos_start),
   .jog_start(jog_start), .servo_off_warning(servo_off_warning),
   .home_valid(home_valid), .home_incomplete_warn(home_incomplete_warn),
   .home_abnormal(home_abnormal), .servo_off_force(servo_off_force),
   .run_enable(run_enable), .warn_code(warn_code)
);
`default_nettype wire

/* test/host_model.sv */
// Host controller and stroke limit switch model.
// Assumes hclk; event pulses last one cycle, limits idle high (on).
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic hclk,
   output var logic [4:0] ev,
   output var logic [1:0] lim,
   output var logic beyond_dog,
   output var logic erase,
   output var logic cntw,
   output var logic sowarn
);
   initial begin
      ev = 5'h00;
      lim = 2'h3;
      beyond_dog = 1'h0;
      erase = 1'h0;
      cntw = 1'h0;
      sowarn = 1'h0;
   end
   // Bits: start, done, creep fail, positioning, jog
   task automatic pulse(input int i);
      @(posedge hclk);
      ev[i] <= 1'h1;
      @(posedge hclk);
      ev <= 5'h00;
   endtask
   // Short run; real homing would take far longer
   task automatic home_run;
      pulse(0);
      repeat (3) @(posedge hclk);
      pulse(1);
   endtask
endmodule // host_model
`default_nettype wire

/* test/homing_status_warning_logic_tb_top.sv */
// Testbench for the homing status block over AHB-Lite.
// Assumes host_model drives the motion side; clk_en dropped once only.
`timescale 1ns/1ps
`default_nettype none
`include "homing_status_defines.vh"
module homing_status_warning_logic_tb_top;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic hclk, hresetn, hsel, hwrite, hreadyout;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans, lim;
   logic [4:0] ev;
   logic bd, er, cw, sw, home_valid, warn, abn, sof, run, reh;
   logic clk_en, hresp;
   logic [15:0] code;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   host_model host (.hclk(hclk), .ev(ev), .lim(lim), .beyond_dog(bd),
      .erase(er), .cntw(cw), .sowarn(sw));
   homing_status_warning_logic DUT (.hclk(hclk), .hresetn(hresetn),
      .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .fwd_stroke_end_limit(lim[0]), .rev_stroke_end_limit(lim[1]),
      .home_start(ev[0]), .home_beyond_dog(bd), .home_done(ev[1]),
      .home_creep_fail(ev[2]), .pos_start(ev[3]), .jog_start(ev[4]),
      .abs_erase_alarm(er), .abs_counter_warning(cw),
      .servo_off_warning(sw), .home_valid(home_valid),
      .home_incomplete_warn(warn), .home_abnormal(abn),
      .servo_off_force(sof), .run_enable(run), .rehome_advised(reh),
      .warn_code(code));
   initial begin
      hclk = 1'h0;
      forever #50 hclk = ~hclk;
   end
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      r = hrdata;
   endtask
   // Extra edge so status outputs have landed before the next access
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
      @(posedge hclk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m = ALL);
      bus(1'h0, a, 32'h0000_0000);
      comparisons++;
      if ((r & m) !== (e & m)) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, r, e);
      end
   endtask
   task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic endt(input string s);
      $display("Test %s done", s);
   endtask
   task print_verdict;
      $display("Counts: comparisons=%0d mismatches=%0d", comparisons,
         n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      hresetn = 1'h0;
      clk_en = 1'h1;
      hsel = 1'h0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hwdata = 32'h0000_0000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (3) @(posedge hclk);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c0);
      rd_chk(`HS_ADDR_GEAR_NUM, 32'h0000_0001);
      rd_chk(8'h40, 32'h0000_0000);
      chk_pin(hresp, 1'h0);
      rd_chk(`HS_ADDR_CODE, 32'h0000_0000);
      endt("reset");
      host.pulse(3);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c2);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0001);
      rd_chk(`HS_ADDR_CODE, 32'h0000_0a90);
      host.pulse(4);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0009);
      host.home_run;
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c1);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0000);
      endt("warning");
      for (int i = 0; i < 5; i++) begin
         host.home_run;
         wr(`HS_ADDR_METHOD + 8'(i * 4), 32'h0000_0005);
         rd_chk(`HS_ADDR_STATUS, 32'h0000_00c2);
         rd_chk(`HS_ADDR_CAUSE, 32'h0000_0010);
      end
      endt("parameters");
      host.home_run;
      host.pulse(0);
      host.pulse(2);
      #1;
      chk_pin(abn, 1'h1);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c6);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0002);
      host.home_run;
      host.pulse(0);
      host.lim[0] <= 1'h0;
      repeat (4) @(posedge hclk);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_0096);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0004);
      host.lim[0] <= 1'h1;
      repeat (3) @(posedge hclk);
      host.home_run;
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c1);
      endt("abnormal");
      wr(`HS_ADDR_CONFIG, 32'h0000_0002);
      chk_pin(run, 1'h1);
      wr(`HS_ADDR_STATIONS, 32'h0000_0007);
      chk_pin(warn, 1'h1);
      chk_pin(run, 1'h1);
      @(posedge hclk);
      host.sowarn <= 1'h1;
      repeat (2) @(posedge hclk);
      #1;
      chk_pin(sof, 1'h1);
      chk_pin(run, 1'h0);
      chk_pin(code, 16'h0ae6);
      rd_chk(`HS_ADDR_CODE, 32'h0000_0ae6);
      host.sowarn <= 1'h0;
      rd_chk(`HS_ADDR_CODE, 32'h0000_0a90);
      endt("servo");
      wr(`HS_ADDR_CONFIG, 32'h0000_0003);
      host.pulse(3);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c2);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0011);
      host.home_run;
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c1);
      host.pulse(0);
      host.pulse(2);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_0006, 32'h0000_0007);
      host.home_run;
      host.erase <= 1'h1;
      host.cntw <= 1'h1;
      host.pulse(3);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_0012, 32'h0000_0013);
      rd_chk(`HS_ADDR_CAUSE, 32'h0000_0020, 32'h0000_0020);
      host.erase <= 1'h0;
      host.cntw <= 1'h0;
      host.home_run;
      #1;
      chk_pin(reh, 1'h0);
      chk_pin(home_valid, 1'h1);
      endt("absolute");
      // Start beyond dog: a stroke end off must not end the run
      @(posedge hclk);
      host.beyond_dog <= 1'h1;
      host.pulse(0);
      host.lim[1] <= 1'h0;
      repeat (3) @(posedge hclk);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_0071);
      chk_pin(abn, 1'h0);
      host.lim[1] <= 1'h1;
      host.beyond_dog <= 1'h0;
      repeat (3) @(posedge hclk);
      host.pulse(1);
      rd_chk(`HS_ADDR_STATUS, 32'h0000_00c1);
      endt("dog");
      // Clock enable low must hold servo_off_force and run_enable
      @(posedge hclk);
      clk_en <= 1'h0;
      host.sowarn <= 1'h1;
      repeat (3) @(posedge hclk);
      #1;
      chk_pin(sof, 1'h0);
      chk_pin(run, 1'h1);
      @(posedge hclk);
      clk_en <= 1'h1;
      repeat (2) @(posedge hclk);
      #1;
      chk_pin(sof, 1'h1);
      chk_pin(code, 16'h0ae6);
      @(posedge hclk);
      host.sowarn <= 1'h0;
      repeat (2) @(posedge hclk);
      #1;
      chk_pin(run, 1'h1);
      chk_pin(code, 16'h0000);
      endt("freeze");
      print_verdict;
   end
endmodule // homing_status_warning_logic_tb_top
`default_nettype wire
